// ==== acsp_port.sv ====
// converter serial frame port: link shifters, check codes, command decode, registers
`default_nettype none

module acsp_port #(
  parameter int DATA_W = 16
) (
  // system
  input  wire  logic              clk,
  input  wire  logic              rst_n,
  // serial link pins
  input  wire  logic              sclk,
  input  wire  logic              cs_n,
  input  wire  logic              serial_in_line,
  output logic                    serial_out_ready_pin_o,
  output logic                    serial_out_ready_pin_oe_n,
  // converter core side
  input  wire  logic [DATA_W-1:0] conv_data,
  input  wire  logic              conv_ready_core_n,
  output logic                    conversion_ready_n,
  // configuration and status seen by the core
  output logic                    output_pin_function_select,
  output logic                    status_header_en,
  output logic                    xfer_check_en,
  output logic                    transfer_error
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (DATA_W != 16) begin : g_chk_w
    $error("acsp_port serves a 16-bit data field only");
  end
  if (acsp_pkg::REG_NUM > 16) begin : g_chk_r
    $error("acsp_port address field holds at most 16 registers");
  end

  // ---------------------------------------------------------------
  // system clock domain declarations
  // ---------------------------------------------------------------
  logic [7:0]        regs_reg [16];
  logic [7:0]        regs_next [16];
  logic              cs_s1_reg;
  logic              cs_s2_reg;
  logic              cs_s3_reg;
  logic              rdy_s1_reg;
  logic              rdy_s2_reg;
  logic              conversion_ready_n_reg;
  logic              core_rdy_d_reg;
  logic [15:0]       data_reg;
  logic              rd_pend_reg;
  logic              rd_pend_next;
  logic [7:0]        rd_byte_reg;
  logic [7:0]        rd_byte_next;
  logic [23:0]       tx_word_reg;

  // ---------------------------------------------------------------
  // link clock domain declarations
  // ---------------------------------------------------------------
  logic              link_rst_n;
  logic [23:0]       rx_sh_reg;
  logic [5:0]        bit_cnt_reg;
  logic [7:0]        crc_acc_reg;
  logic              sdo_reg;
  logic              started_reg;

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  wire logic [7:0]  cfg2        = regs_reg[acsp_pkg::ADDR_CFG2];
  wire logic [7:0]  cfg4        = regs_reg[acsp_pkg::ADDR_CFG4];
  wire logic [7:0]  status_byte = regs_reg[acsp_pkg::ADDR_STATUS];
  wire logic        pin_dual    = cfg2[acsp_pkg::CFG2_PINSEL];
  wire logic        stat_en     = cfg4[acsp_pkg::CFG4_STATUS];
  wire logic        chk_en      = cfg4[acsp_pkg::CFG4_CHECK];
  wire logic        err_flag    = status_byte[acsp_pkg::STAT_ERR_BIT];

  assign output_pin_function_select = pin_dual;
  assign status_header_en           = stat_en;
  assign xfer_check_en              = chk_en;
  assign transfer_error             = err_flag;

  // ---------------------------------------------------------------
  // select and ready synchronisers
  // ---------------------------------------------------------------
  // frame end is seen as the synchronised select rising; the link clock is still then
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_reg  <= 1'b1;
      cs_s2_reg  <= 1'b1;
      cs_s3_reg  <= 1'b1;
      rdy_s1_reg <= 1'b1;
      rdy_s2_reg <= 1'b1;
    end else begin
      cs_s1_reg  <= cs_n;
      cs_s2_reg  <= cs_s1_reg;
      cs_s3_reg  <= cs_s2_reg;
      rdy_s1_reg <= conv_ready_core_n;
      rdy_s2_reg <= rdy_s1_reg;
    end
  end

  wire logic frame_end  = cs_s2_reg & ~cs_s3_reg;
  wire logic link_idle  = cs_s2_reg & cs_s3_reg;

  // ---------------------------------------------------------------
  // command decode at frame end
  // ---------------------------------------------------------------
  // only the newest 16 or 24 input bits count, whatever the frame length
  wire logic [15:0] cmd      = chk_en ? rx_sh_reg[23:8] : rx_sh_reg[15:0];
  wire logic [7:0]  cmd_crc  = acsp_pkg::crc16(cmd);
  wire logic        crc_ok   = !chk_en || (cmd_crc == rx_sh_reg[7:0]);
  wire logic [1:0]  cmd_op   = cmd[15:14];
  wire logic [3:0]  cmd_addr = cmd[11:8];
  wire logic [7:0]  cmd_data = cmd[7:0];
  wire logic        addr_ok  = {1'b0, cmd_addr} < 5'(acsp_pkg::REG_NUM);
  wire logic        is_read  = frame_end && crc_ok && cmd_op == acsp_pkg::OP_READ;
  wire logic        is_write = frame_end && crc_ok && cmd_op == acsp_pkg::OP_WRITE;
  wire logic        to_stat  = cmd_addr == acsp_pkg::ADDR_STATUS;
  // with the error flag up only the status register may be written
  wire logic        wr_ok    = is_write && addr_ok && (!err_flag || to_stat);
  wire logic        crc_fail = frame_end && !crc_ok;
  wire logic        clr_err  = wr_ok && to_stat && cmd_data[acsp_pkg::STAT_ERR_BIT];

  // register file next state; a new check failure beats a clear in the same frame
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      regs_next[i] = regs_reg[i];
    end
    if (wr_ok && !to_stat) begin
      regs_next[cmd_addr] = cmd_data;
    end
    regs_next[acsp_pkg::ADDR_STATUS][acsp_pkg::STAT_RDY_BIT] = conversion_ready_n_reg;
    if (clr_err) begin
      regs_next[acsp_pkg::ADDR_STATUS][acsp_pkg::STAT_ERR_BIT] = 1'b0;
    end
    if (crc_fail) begin
      regs_next[acsp_pkg::ADDR_STATUS][acsp_pkg::STAT_ERR_BIT] = 1'b1;
    end
  end

  // pending read answer for the next frame; a failed read frame returns data instead
  always_comb begin
    rd_pend_next = rd_pend_reg;
    rd_byte_next = rd_byte_reg;
    if (frame_end) begin
      rd_pend_next = is_read;
      rd_byte_next = addr_ok ? regs_reg[cmd_addr] : acsp_pkg::PAD_BYTE;
    end
  end

  // registers and read state; reset leaves both optional bytes off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        regs_reg[i] <= acsp_pkg::REG_RESET;
      end
      rd_pend_reg <= 1'b0;
      rd_byte_reg <= acsp_pkg::PAD_BYTE;
    end else begin
      regs_reg    <= regs_next;
      rd_pend_reg <= rd_pend_next;
      rd_byte_reg <= rd_byte_next;
    end
  end

  // ---------------------------------------------------------------
  // conversion data and dedicated ready output
  // ---------------------------------------------------------------
  // ready follows the core at all times, independent of select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_ready_n_reg       <= 1'b1;
      core_rdy_d_reg <= 1'b1;
      data_reg       <= '0;
    end else begin
      conversion_ready_n_reg       <= rdy_s2_reg;
      core_rdy_d_reg <= rdy_s2_reg;
      if (core_rdy_d_reg && !rdy_s2_reg && link_idle) begin
        data_reg <= conv_data;
      end
    end
  end

  assign conversion_ready_n = conversion_ready_n_reg;

  // ---------------------------------------------------------------
  // output word, held still while a frame is open
  // ---------------------------------------------------------------
  // the link side reads this word and the config bits only while select is low,
  // so updating them only between frames keeps the crossing quasi-static
  wire logic [15:0] field     = rd_pend_reg ? {rd_byte_reg, acsp_pkg::PAD_BYTE} : data_reg;
  wire logic [23:0] word_next = stat_en ? {status_byte, field}
                                        : {field, acsp_pkg::PAD_BYTE};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_word_reg <= '0;
    end else if (link_idle) begin
      tx_word_reg <= word_next;
    end
  end

  // ---------------------------------------------------------------
  // link domain: select high holds the output shifter in reset
  // ---------------------------------------------------------------
  assign link_rst_n = rst_n & ~cs_n;

  wire logic [5:0] data_bits  = acsp_pkg::BASE_BITS +
                                (stat_en ? acsp_pkg::OPT_BITS : 6'h00);
  wire logic [5:0] frame_bits = data_bits +
                                (chk_en ? acsp_pkg::OPT_BITS : 6'h00);
  wire logic       in_data    = bit_cnt_reg < data_bits;
  wire logic       in_frame   = bit_cnt_reg < frame_bits;
  wire logic       tx_bit     = tx_word_reg[5'(23 - bit_cnt_reg[4:0])];

  // input shifter; sampled on falling edges, kept across select so the
  // system side can decode it after the frame, line idle level is irrelevant
  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_reg <= '0;
    end else if (!cs_n) begin
      rx_sh_reg <= {rx_sh_reg[22:0], serial_in_line};
    end
  end

  // output shifter and check accumulator on rising edges
  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= '0;
      crc_acc_reg <= acsp_pkg::CRC_SEED;
      sdo_reg     <= 1'b0;
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
      if (in_frame) begin
        bit_cnt_reg <= bit_cnt_reg + 6'h01;
      end
      if (in_data) begin
        sdo_reg     <= tx_bit;
        crc_acc_reg <= acsp_pkg::crc_step(crc_acc_reg, tx_bit);
      end else if (in_frame) begin
        sdo_reg     <= crc_acc_reg[7];
        crc_acc_reg <= {crc_acc_reg[6:0], 1'b0};
      end else begin
        sdo_reg     <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  // before the first rising edge the dual-function pin shows data ready;
  // the enable follows the raw select so the pin floats at once
  assign serial_out_ready_pin_o    = started_reg ? sdo_reg
                                                 : (pin_dual & conversion_ready_n_reg);
  assign serial_out_ready_pin_oe_n = cs_n;

endmodule

`default_nettype wire

// ==== acsp_pkg.sv ====
// constants, check-code helpers and mode codes for the converter serial frame port
`default_nettype none

package acsp_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          REG_NUM        = 15;      // valid addresses 0h..Eh
  localparam logic [3:0]  ADDR_STATUS    = 4'h2;
  localparam logic [3:0]  ADDR_CFG2      = 4'h6;    // second_config_register
  localparam logic [3:0]  ADDR_CFG4      = 4'h7;    // fourth_config_register
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam int          STAT_ERR_BIT   = 0;       // transfer-error flag
  localparam int          STAT_RDY_BIT   = 7;       // conversion data not yet ready
  localparam int          CFG2_PINSEL    = 0;       // output_pin_function_select
  localparam int          CFG4_STATUS    = 0;       // status header enable
  localparam int          CFG4_CHECK     = 1;       // transfer check enable

  // ---------------------------------------------------------------
  // commands and check code
  // ---------------------------------------------------------------
  localparam logic [1:0]  OP_READ        = 2'h1;    // 40h + address
  localparam logic [1:0]  OP_WRITE       = 2'h2;    // 80h + address
  localparam logic [7:0]  CRC_SEED       = 8'hFF;   // leading byte inversion
  localparam logic [7:0]  CRC_POLY       = 8'h07;   // 100000111 without the top term
  localparam logic [7:0]  PAD_BYTE       = 8'h00;
  localparam logic [5:0]  BASE_BITS      = 6'h10;   // 16-bit minimum frame
  localparam logic [5:0]  OPT_BITS       = 6'h08;   // each optional byte

  // one shift of the check divider, most significant bit first
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic din);
    logic fb;
    fb = crc[7] ^ din;
    return {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  // check code of two command bytes; seeding with ones equals inverting the first byte
  function automatic logic [7:0] crc16(input logic [15:0] arg);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      c = crc_step(c, arg[i]);
    end
    return c;
  endfunction

endpackage

`default_nettype wire

// ==== acsp_port_assertions.sv ====
// concurrent checks on the serial frame port pins
`default_nettype none
module acsp_port_assertions (
  // system and link
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_out_ready_pin_o,
  input wire logic serial_out_ready_pin_oe_n,
  // core and configuration
  input wire logic conv_ready_core_n,
  input wire logic conversion_ready_n,
  input wire logic output_pin_function_select,
  input wire logic status_header_en,
  input wire logic xfer_check_en,
  input wire logic transfer_error
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ready path: two sync flops plus one register, select plays no part
  sequence s_rdy_fell;
    $fell(conv_ready_core_n);
  endsequence
  sequence s_rdy_rose;
    $rose(conv_ready_core_n);
  endsequence
  property p_rdy_fall;
    s_rdy_fell |-> ##3 !conversion_ready_n;
  endproperty
  a_rdy_fall: assert property (p_rdy_fall) else $error("ready fall late");
  property p_rdy_rise;
    s_rdy_rose |-> !conversion_ready_n ##3 conversion_ready_n;
  endproperty
  a_rdy_rise: assert property (p_rdy_rise) else $error("ready rise late");
  // pin floats exactly while select is high
  property p_oe;
    serial_out_ready_pin_oe_n == cs_n;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  // inside a frame the pin moves only on a rising link clock
  property p_out_rise;
    !cs_n && !$past(cs_n) && $changed(serial_out_ready_pin_o) |-> $rose(sclk);
  endproperty
  a_out_rise: assert property (p_out_rise) else $error("pin moved off rise");
  // decode waits for select high, so nothing moves mid-frame
  property p_cfg_end;
    $changed({output_pin_function_select, status_header_en, xfer_check_en, transfer_error})
      |-> cs_n && $past(cs_n, 2);
  endproperty
  a_cfg_end: assert property (p_cfg_end) else $error("config moved in frame");
  property p_err_rise;
    $rose(transfer_error) |-> xfer_check_en;
  endproperty
  a_err_rise: assert property (p_err_rise) else $error("error without check");
  property p_err_hold;
    transfer_error && !cs_n |=> transfer_error;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error lost in frame");
  property p_err_blocks;
    $past(transfer_error) |-> $stable({output_pin_function_select, status_header_en,
                                       xfer_check_en});
  endproperty
  a_err_blocks: assert property (p_err_blocks) else $error("write passed error");
endmodule

bind acsp_port acsp_port_assertions u_chk (
  .clk, .rst_n, .sclk, .cs_n, .serial_out_ready_pin_o, .serial_out_ready_pin_oe_n,
  .conv_ready_core_n, .conversion_ready_n, .output_pin_function_select,
  .status_header_en, .xfer_check_en, .transfer_error
);
`default_nettype wire

// ==== acsp_host_model.sv ====
// host controller model driving the link pins
`default_nettype none
module acsp_host_model (
  // link pins
  output var logic  sclk,
  output var logic  cs_n,
  output var logic  serial_in_line,
  input  wire logic serial_out_ready_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 80;
  // idle: clock low and still, select high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in_line = 1'b0;
  end
  // the 3 ns offset keeps link edges off the system clock edges
  task automatic open_frame();
    #3 cs_n = 1'b0;
    #HALF;
  endtask
  // mode 1: drive on rise, both sides sample on fall, msb first
  task automatic shift(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b1;
      serial_in_line = tx[i];
      #HALF sclk = 1'b0;
      rx[i] = serial_out_ready_pin_o;
      #HALF;
    end
    cs_n = 1'b1;
    serial_in_line = ~serial_in_line;
    #200;
  endtask
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    open_frame();
    shift(n, tx, rx);
  endtask
endmodule
`default_nettype wire

// ==== acsp_port_tb.sv ====
// self-checking bench for the serial frame port
`default_nettype none
module acsp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // commands built from the package codes
  localparam logic [7:0] wr_cfg2 = {acsp_pkg::OP_WRITE, 2'b00, acsp_pkg::ADDR_CFG2};
  localparam logic [7:0] wr_cfg4 = {acsp_pkg::OP_WRITE, 2'b00, acsp_pkg::ADDR_CFG4};
  localparam logic [7:0] wr_stat = {acsp_pkg::OP_WRITE, 2'b00, acsp_pkg::ADDR_STATUS};
  localparam logic [7:0] rd_cfg4 = {acsp_pkg::OP_READ, 2'b00, acsp_pkg::ADDR_CFG4};
  // bench signals, named as the ports they meet
  logic        clk;
  logic        rst_n;
  logic [15:0] conv_data;
  logic        conv_ready_core_n;
  wire logic   sclk, cs_n, serial_in_line, serial_out_ready_pin_o, serial_out_ready_pin_oe_n;
  wire logic   conversion_ready_n, output_pin_function_select;
  wire logic   status_header_en, xfer_check_en, transfer_error;
  logic [31:0] rx;
  logic [31:0] e24;
  int          miscompares;
  int          comparisons;
  // system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // design and far-side host
  acsp_port #(.DATA_W(16)) dut (
    .clk, .rst_n, .sclk, .cs_n, .serial_in_line, .serial_out_ready_pin_o,
    .serial_out_ready_pin_oe_n, .conv_data, .conv_ready_core_n, .conversion_ready_n,
    .output_pin_function_select, .status_header_en, .xfer_check_en, .transfer_error
  );
  acsp_host_model host (.sclk, .cs_n, .serial_in_line, .serial_out_ready_pin_o);
  // comparison and closing tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t frame got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
  endtask
  // bench-side check code, seeded with ones, msb first
  function automatic logic [7:0] crc(input int n, input logic [31:0] v);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // core hands over a word on the falling ready edge
  task automatic latch(input logic [15:0] v);
    @(posedge clk);
    conv_data <= v;
    conv_ready_core_n <= 1'b1;
    cycles(6);
    conv_ready_core_n <= 1'b0;
    cycles(6);
  endtask
  // one frame; check mode adds a leading pad and the code, flip corrupts it
  task automatic go(input logic [7:0] b1, input logic [7:0] b2, input int n,
                    input bit chk, input logic [7:0] flip);
    logic [23:0] w;
    w = {b1, b2, crc(16, {16'h0000, b1, b2}) ^ flip};
    @(posedge clk);
    host.xfer(n, chk ? {8'h00, w} : {16'h0000, b1, b2}, rx);
  endtask
  task automatic t_conv();
    latch(16'hA5C3);
    go(wr_cfg2, 8'h01, 16, 0, 8'h00);
    cmp(rx, 32'h0000A5C3);
    cmp_bit(output_pin_function_select, 1'b1);
  endtask
  // dual pin shows not-ready before the first rise, data-only shows low
  task automatic t_pin();
    @(posedge clk);
    conv_ready_core_n <= 1'b1;
    cycles(6);
    host.open_frame();
    cmp_bit(serial_out_ready_pin_oe_n, 1'b0);
    cmp_bit(serial_out_ready_pin_o, 1'b1);
    cmp_bit(conversion_ready_n, 1'b1);
    host.shift(16, {16'h0000, wr_cfg2, 8'h00}, rx);
    cmp(rx, 32'h0000A5C3);
    cmp_bit(serial_out_ready_pin_oe_n, 1'b1);
    host.open_frame();
    cmp_bit(serial_out_ready_pin_o, 1'b0);
    host.shift(16, 32'h0, rx);
  endtask
  task automatic t_check();
    go(wr_cfg4, 8'h02, 16, 0, 8'h00);
    cmp_bit(xfer_check_en, 1'b1);
    latch(16'h3C5A);
    go(8'h00, 8'h00, 24, 1, 8'h00);
    cmp(rx, e24);
    cmp_bit(transfer_error, 1'b0);
    cmp({24'h000000, crc(16, 32'h00000000)}, 32'h000000D7);
  endtask
  // bad write, blocked write, bad read, honoured read, then clear
  task automatic t_err();
    go(wr_cfg2, 8'h01, 24, 1, 8'h01);
    cmp_bit(transfer_error, 1'b1);
    cmp_bit(output_pin_function_select, 1'b0);
    go(wr_cfg2, 8'h01, 24, 1, 8'h00);
    cmp_bit(output_pin_function_select, 1'b0);
    go(rd_cfg4, 8'h00, 24, 1, 8'h01);
    go(rd_cfg4, 8'h00, 24, 1, 8'h00);
    cmp(rx, e24);
    go(wr_stat, 8'h01, 24, 1, 8'h00);
    cmp(rx, {16'h0002, 8'h00, crc(16, 32'h0200)});
    cmp_bit(transfer_error, 1'b0);
  endtask
  task automatic t_hdr();
    go(wr_cfg4, 8'h03, 32, 1, 8'h00);
    cmp(rx, {e24[23:0], 8'h00});
    cmp_bit(status_header_en, 1'b1);
    go(8'h00, 8'h00, 32, 1, 8'h00);
    cmp(rx, {8'h00, 16'h3C5A, crc(24, 32'h003C5A)});
  endtask
  // reset mid-run returns to plain 16-bit frames
  task automatic t_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    cycles(10);
    rst_n <= 1'b1;
    cycles(3);
    cmp_bit(xfer_check_en, 1'b0);
    // nonzero data so the read answer is told apart from conversion data
    latch(16'h3C5A);
    go(rd_cfg4, 8'h00, 24, 0, 8'h00);
    cmp(rx, 32'h003C5A00);
    go(8'h00, 8'h00, 24, 0, 8'h00);
    cmp(rx, 32'h00000000);
  endtask
  // main sequence
  initial begin
    rst_n = 1'b1;
    conv_data = 16'h0000;
    conv_ready_core_n = 1'b1;
    miscompares = 0;
    comparisons = 0;
    e24 = {8'h00, 16'h3C5A, crc(16, 32'h3C5A)};
    // drop reset after time zero so each flop reset directly by rst_n sees a real falling edge
    #1;
    rst_n = 1'b0;
    cycles(10);
    rst_n <= 1'b1;
    cycles(3);
    t_conv();
    t_pin();
    t_check();
    t_err();
    t_hdr();
    t_reset();
    end_of_test();
  end
  // hang guard, far beyond the longest run
  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
